/* rtl/rcp_stage.sv */
// How it works
// R1: Monitor one source: coarse, sensitive, calculated
// R2: Magnitude RMS, TRMS or peak, measured inputs
// R3: TRMS covers up to 32 harmonics
// R4: Magnitudes refreshed on a 5 ms base
// R5: Side 1 or side 2 measurement module
// R6: Remote threshold change only when allowed
// R7: Five modes, settable when individual mode enabled
// R8: Forced status when stage forcing enabled
// R9: General settings independent of setting group
// R10: Ratio of measured magnitude to threshold
// R11: Pick up when magnitude exceeds threshold
// R12: Release below 97 percent of threshold
// R13: One threshold for all channels
// R14: Threshold step 0.0001 In, max 40 In
// R15: Group change alters threshold while running
// R16: Pick-up gives start, or blocked if blocked
// R17: Blocking during start clears start, release timing
// R18: Block must arrive 5 ms before delay
// R19: Evaluate once per new measurement
module rcp_stage #(
    parameter int TICK_CYCLES = rcp_pkg::TICK_CYCLES
) (
    // Clock and reset
    input wire logic ref_clk,
    input wire logic rst_n,
    // APB slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [rcp_pkg::ADDR_W-1:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // Measurement front end
    input wire rcp_pkg::rcp_meas_s meas_side1,
    input wire rcp_pkg::rcp_meas_s meas_side2,
    // System
    input wire logic block_in,
    input wire logic [rcp_pkg::GRP_W-1:0] setting_group,
    // Stage outputs
    output rcp_pkg::rcp_out_s stage_o
);
    import rcp_pkg::*;

    // ****************************************************************
    // Registers
    // ****************************************************************
    logic [CTRL_W-1:0] ctrl_q;
    logic [GLB_W-1:0] glb_q;
    logic [THR_W-1:0] thr_q [NGROUPS];
    logic [31:0] prdata_q;
    logic pready_q;
    logic pslverr_q;
    logic [TICK_W-1:0] tick_q;
    logic [MEAS_W-1:0] meas_q;
    logic eval_q;
    logic picked_q;
    logic start_q;
    logic blocked_q;
    logic release_q;
    logic [RATIO_W-1:0] ratio_q;
    rcp_out_s out_q;

    // ****************************************************************
    // Bus decode
    // ****************************************************************
    logic setup;
    logic access;
    logic wr;
    logic hit_ctrl;
    logic hit_glb;
    logic hit_remote;
    logic hit_status;
    logic hit_meas;
    logic hit_ratio;
    logic hit_thr;
    logic hit_any;
    logic [GRP_W-1:0] thr_idx;
    logic [THR_W-1:0] wr_thr;
    logic thr_ok;
    logic ctrl_ok;
    logic remote_ok;
    logic refuse;

    assign setup = psel && !penable;
    assign access = psel && penable && pready_q;
    assign wr = access && pwrite;
    assign hit_ctrl = paddr == OFS_CTRL;
    assign hit_glb = paddr == OFS_GLOBAL;
    assign hit_remote = paddr == OFS_REMOTE;
    assign hit_status = paddr == OFS_STATUS;
    assign hit_meas = paddr == OFS_MEAS;
    assign hit_ratio = paddr == OFS_RATIO;
    assign hit_thr = paddr >= OFS_THR_BASE && paddr <= OFS_THR_LAST
        && paddr[1:0] == 2'b00;
    assign hit_any = hit_ctrl || hit_glb || hit_remote || hit_status
        || hit_meas || hit_ratio || hit_thr;
    assign thr_idx = paddr[GRP_W+1:2];
    assign wr_thr = pwdata[THR_W-1:0];
    // Out-of-range steps are refused rather than clamped
    assign thr_ok = wr_thr >= THR_MIN && wr_thr <= THR_MAX
        && pwdata[31:THR_W] == '0; // R14
    assign ctrl_ok = pwdata[CTRL_SRC_LSB+:2] <= 2'(SRC_CALC)
        && pwdata[CTRL_MAG_LSB+:2] <= 2'(MAG_PP)
        && pwdata[CTRL_MODE_LSB+:3] <= 3'(MODE_OFF);
    assign remote_ok = ctrl_q[CTRL_REMOTE] && thr_ok; // R6
    assign refuse = !hit_any
        || (pwrite && hit_ctrl && !ctrl_ok)
        || (pwrite && hit_remote && !remote_ok)
        || (pwrite && hit_thr && !thr_ok)
        || (pwrite && (hit_status || hit_meas || hit_ratio));

    // ****************************************************************
    // Settings decode
    // ****************************************************************
    rcp_src_e src;
    rcp_mag_e mag;
    rcp_mode_e mode_eff;
    logic indiv_en;
    logic force_en;
    rcp_cond_e force_val;
    logic [CTRL_W-1:0] ctrl_wr;

    assign src = rcp_src_e'(ctrl_q[CTRL_SRC_LSB+:2]);
    assign mag = rcp_mag_e'(ctrl_q[CTRL_MAG_LSB+:2]);
    assign indiv_en = glb_q[GLB_INDIV];
    assign force_en = glb_q[GLB_FORCE];
    assign force_val = rcp_cond_e'(glb_q[GLB_FVAL_LSB+:2]);
    assign mode_eff = indiv_en ?
        rcp_mode_e'(ctrl_q[CTRL_MODE_LSB+:3]) : MODE_ON; // R7
    // Mode field keeps its value while individual setting is off
    assign ctrl_wr = indiv_en ? pwdata[CTRL_W-1:0] :
        {ctrl_q[CTRL_W-1:CTRL_MODE_LSB], pwdata[CTRL_MODE_LSB-1:0]}; // R7

    // ****************************************************************
    // Source and magnitude selection
    // ****************************************************************
    rcp_meas_s side_sel;
    logic [MEAS_W-1:0] coarse_mag;
    logic [MEAS_W-1:0] sens_mag;
    logic [MEAS_W-1:0] sel_mag;
    logic [THR_W-1:0] thr_act;

    assign side_sel = ctrl_q[CTRL_SIDE] ? meas_side2 : meas_side1; // R5
    assign coarse_mag = mag == MAG_TRMS ? side_sel.coarse_trms : // R3
        mag == MAG_PP ? side_sel.coarse_pp : side_sel.coarse_rms; // R2
    assign sens_mag = mag == MAG_TRMS ? side_sel.sens_trms : // R3
        mag == MAG_PP ? side_sel.sens_pp : side_sel.sens_rms; // R2
    // Calculated value has only a fundamental, magnitude choice ignored
    assign sel_mag = src == SRC_SENS ? sens_mag :
        src == SRC_CALC ? side_sel.calc : coarse_mag; // R1 R2
    // General settings live in ctrl_q, untouched by the group select
    assign thr_act = thr_q[setting_group]; // R9 R13 R15

    // ****************************************************************
    // Time base and evaluation
    // ****************************************************************
    logic tick;
    logic picked_d;
    logic blk;
    logic pick_n;
    logic rise;
    logic start_n;
    logic blocked_n;
    logic ratio_done;
    logic [RATIO_W-1:0] ratio_res;

    assign tick = tick_q == TICK_W'(TICK_CYCLES - 1); // R4

    rcp_hyst_cmp u_cmp (
        .meas (meas_q),
        .thr (thr_act),
        .picked (picked_q),
        .picked_d (picked_d)
    );

    rcp_ratio_div u_div (
        .ref_clk (ref_clk),
        .rst_n (rst_n),
        .start (eval_q),
        .meas (meas_q),
        .thr (thr_act),
        .ratio (ratio_res),
        .done (ratio_done)
    );

    // Block sampled once per evaluation; late blocking cannot stop a trip
    assign blk = block_in || mode_eff == MODE_BLOCKED
        || mode_eff == MODE_TEST_BLOCKED; // R16 R18
    assign pick_n = mode_eff != MODE_OFF && picked_d; // R11 R12
    assign rise = pick_n && !picked_q;
    assign start_n = !pick_n ? 1'b0 : rise ? !blk :
        blk ? 1'b0 : start_q; // R16 R17
    assign blocked_n = !pick_n ? 1'b0 : rise ? blk :
        (blk && start_q) ? 1'b1 : blocked_q; // R16 R17

    // ****************************************************************
    // Output mapping
    // ****************************************************************
    rcp_out_s out_d;
    rcp_cond_e cond_n;

    assign cond_n = force_en ? force_val : // R8
        blocked_q ? COND_BLOCKED : start_q ? COND_START : COND_NORMAL;
    assign out_d.cond = cond_n;
    assign out_d.start = cond_n == COND_START;
    assign out_d.trip = cond_n == COND_TRIP;
    assign out_d.blocked = cond_n == COND_BLOCKED;
    assign out_d.release_pulse = release_q; // R17
    assign out_d.test = mode_eff == MODE_TEST
        || mode_eff == MODE_TEST_BLOCKED; // R7

    // ****************************************************************
    // Read mux
    // ****************************************************************
    logic [31:0] rd_mux;

    assign rd_mux = hit_ctrl ? 32'(ctrl_q) :
        hit_glb ? 32'(glb_q) :
        hit_remote ? 32'(thr_act) :
        hit_status ? 32'({out_q.cond, out_q.test, blocked_q, start_q,
            picked_q}) :
        hit_meas ? 32'(meas_q) :
        hit_ratio ? 32'(ratio_q) : // R10
        hit_thr ? 32'(thr_q[thr_idx]) : 32'h0000_0000;

    // ****************************************************************
    // Clocked logic
    // ****************************************************************
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            pready_q <= 1'b0;
            pslverr_q <= 1'b0;
            prdata_q <= '0;
        end else begin
            pready_q <= setup;
            pslverr_q <= setup && refuse;
            prdata_q <= (setup && !pwrite) ? rd_mux : 32'h0000_0000;
        end
    end

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            ctrl_q <= CTRL_RST;
            glb_q <= GLB_RST;
        end else begin
            if (wr && hit_ctrl && ctrl_ok) begin
                ctrl_q <= ctrl_wr; // R9
            end
            if (wr && hit_glb) begin
                glb_q <= pwdata[GLB_W-1:0];
            end
        end
    end

    for (genvar g = 0; g < NGROUPS; g++) begin : g_thr
        always_ff @(posedge ref_clk or negedge rst_n) begin
            if (!rst_n) begin
                thr_q[g] <= THR_RST; // R14
            end else if (wr && hit_thr && thr_ok
                && thr_idx == GRP_W'(g)) begin
                thr_q[g] <= wr_thr; // R14
            end else if (wr && hit_remote && remote_ok
                && setting_group == GRP_W'(g)) begin
                thr_q[g] <= wr_thr; // R6
            end
        end
    end

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            tick_q <= '0;
            meas_q <= '0;
            eval_q <= 1'b0;
        end else begin
            tick_q <= tick ? '0 : tick_q + TICK_W'(1); // R4
            eval_q <= tick; // R19
            if (tick) begin
                meas_q <= sel_mag; // R4
            end
        end
    end

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            picked_q <= 1'b0;
            start_q <= 1'b0;
            blocked_q <= 1'b0;
            release_q <= 1'b0;
        end else begin
            release_q <= eval_q && start_q && !start_n; // R17
            if (eval_q) begin
                picked_q <= pick_n; // R19
                start_q <= start_n; // R16
                blocked_q <= blocked_n; // R16
            end
        end
    end

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            ratio_q <= '0;
            out_q <= '0;
        end else begin
            out_q <= out_d;
            if (ratio_done) begin
                ratio_q <= ratio_res; // R10
            end
        end
    end

    assign prdata = prdata_q;
    assign pready = pready_q;
    assign pslverr = pslverr_q;
    assign stage_o = out_q;

endmodule : rcp_stage

/* rtl/rcp_pkg.sv */
package rcp_pkg;

    // ****************************************************************
    // Widths
    // ****************************************************************
    localparam int MEAS_W = 20;
    localparam int THR_W = 19;
    localparam int FRAC_W = 8;
    localparam int RATIO_W = MEAS_W + FRAC_W;
    localparam int PCT_W = 7;
    localparam int ADDR_W = 12;
    localparam int NGROUPS = 8;
    localparam int GRP_W = 3;

    // ****************************************************************
    // Threshold in units of 0.0001 x In
    // ****************************************************************
    localparam logic [THR_W-1:0] THR_MIN = 19'h00001;
    localparam logic [THR_W-1:0] THR_MAX = 19'h61a80;
    localparam logic [THR_W-1:0] THR_RST = 19'h02ee0;
    localparam logic [PCT_W-1:0] DROP_PCT = 7'h61;
    localparam logic [PCT_W-1:0] FULL_PCT = 7'h64;

    // ****************************************************************
    // Measurement time base
    // ****************************************************************
    localparam int TICK_MS = 5;
    localparam int CLK_KHZ = 125000;
    localparam int TICK_CYCLES = TICK_MS * CLK_KHZ;
    localparam int TICK_W = 20;

    // ****************************************************************
    // Register offsets (byte addresses)
    // ****************************************************************
    localparam logic [ADDR_W-1:0] OFS_CTRL = 12'h000;
    localparam logic [ADDR_W-1:0] OFS_GLOBAL = 12'h004;
    localparam logic [ADDR_W-1:0] OFS_REMOTE = 12'h008;
    localparam logic [ADDR_W-1:0] OFS_STATUS = 12'h00c;
    localparam logic [ADDR_W-1:0] OFS_MEAS = 12'h010;
    localparam logic [ADDR_W-1:0] OFS_RATIO = 12'h014;
    localparam logic [ADDR_W-1:0] OFS_THR_BASE = 12'h020;
    localparam logic [ADDR_W-1:0] OFS_THR_LAST = 12'h03c;

    // ****************************************************************
    // Field layout
    // ****************************************************************
    localparam int CTRL_W = 9;
    localparam int CTRL_SRC_LSB = 0;
    localparam int CTRL_MAG_LSB = 2;
    localparam int CTRL_SIDE = 4;
    localparam int CTRL_REMOTE = 5;
    localparam int CTRL_MODE_LSB = 6;
    localparam logic [CTRL_W-1:0] CTRL_RST = 9'h000;
    localparam int GLB_W = 4;
    localparam int GLB_INDIV = 0;
    localparam int GLB_FORCE = 1;
    localparam int GLB_FVAL_LSB = 2;
    localparam logic [GLB_W-1:0] GLB_RST = 4'h0;

    typedef enum logic [1:0] {SRC_COARSE, SRC_SENS, SRC_CALC} rcp_src_e;
    typedef enum logic [1:0] {MAG_RMS, MAG_TRMS, MAG_PP} rcp_mag_e;
    typedef enum logic [2:0] {
        MODE_ON, MODE_BLOCKED, MODE_TEST, MODE_TEST_BLOCKED, MODE_OFF
    } rcp_mode_e;
    typedef enum logic [1:0] {
        COND_NORMAL, COND_START, COND_TRIP, COND_BLOCKED
    } rcp_cond_e;

    typedef struct packed {
        logic [MEAS_W-1:0] coarse_rms;
        logic [MEAS_W-1:0] coarse_trms;
        logic [MEAS_W-1:0] coarse_pp;
        logic [MEAS_W-1:0] sens_rms;
        logic [MEAS_W-1:0] sens_trms;
        logic [MEAS_W-1:0] sens_pp;
        logic [MEAS_W-1:0] calc;
    } rcp_meas_s;

    typedef struct packed {
        logic start;
        logic trip;
        logic blocked;
        logic release_pulse;
        logic test;
        rcp_cond_e cond;
    } rcp_out_s;

endpackage : rcp_pkg

/* rtl/rcp_hyst_cmp.sv */
module rcp_hyst_cmp (
    // Operands
    input wire logic [rcp_pkg::MEAS_W-1:0] meas,
    input wire logic [rcp_pkg::THR_W-1:0] thr,
    input wire logic picked,
    // Result
    output logic picked_d
);
    import rcp_pkg::*;

    // ****************************************************************
    // Scaled compare, no division needed
    // ****************************************************************
    logic [MEAS_W+PCT_W-1:0] meas_pct;
    logic [MEAS_W+PCT_W-1:0] thr_pct;
    logic above;
    logic below_drop;

    assign meas_pct = meas * FULL_PCT;
    assign thr_pct = {{(MEAS_W-THR_W){1'b0}}, thr} * DROP_PCT;
    assign above = meas > {{(MEAS_W-THR_W){1'b0}}, thr}; // R11
    assign below_drop = meas_pct < thr_pct; // R12
    assign picked_d = picked ? !below_drop : above; // R12

endmodule : rcp_hyst_cmp

/* rtl/rcp_ratio_div.sv */
module rcp_ratio_div (
    // Clock and reset
    input wire logic ref_clk,
    input wire logic rst_n,
    // Request
    input wire logic start,
    input wire logic [rcp_pkg::MEAS_W-1:0] meas,
    input wire logic [rcp_pkg::THR_W-1:0] thr,
    // Result
    output logic [rcp_pkg::RATIO_W-1:0] ratio,
    output logic done
);
    import rcp_pkg::*;

    // ****************************************************************
    // Serial restoring divider, one bit per clock
    // ****************************************************************
    logic [RATIO_W-1:0] quo_q;
    logic [THR_W:0] rem_q;
    logic [THR_W-1:0] div_q;
    logic [4:0] cnt_q;
    logic busy_q;
    logic done_q;
    logic [THR_W:0] shifted;
    logic fits;

    assign shifted = {rem_q[THR_W-1:0], quo_q[RATIO_W-1]};
    assign fits = shifted >= {1'b0, div_q};

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            quo_q <= '0;
            rem_q <= '0;
            div_q <= THR_RST;
            cnt_q <= '0;
            busy_q <= 1'b0;
            done_q <= 1'b0;
        end else if (start) begin
            quo_q <= {meas, {FRAC_W{1'b0}}};
            rem_q <= '0;
            div_q <= thr;
            cnt_q <= 5'(RATIO_W - 1);
            busy_q <= 1'b1;
            done_q <= 1'b0;
        end else if (busy_q) begin
            rem_q <= fits ? shifted - {1'b0, div_q} : shifted;
            quo_q <= {quo_q[RATIO_W-2:0], fits};
            cnt_q <= cnt_q - 5'h01;
            busy_q <= cnt_q != 5'h00;
            done_q <= cnt_q == 5'h00;
        end else begin
            done_q <= 1'b0;
        end
    end

    assign ratio = quo_q;
    assign done = done_q;

endmodule : rcp_ratio_div

/* tb/rcp_stage_assertions.sv */
module rcp_stage_assertions #(
    parameter int TICK_CYCLES = 40
) (
    // Clock and reset
    input wire logic ref_clk,
    input wire logic rst_n,
    // APB
    input wire logic psel,
    input wire logic penable,
    input wire logic [rcp_pkg::ADDR_W-1:0] paddr,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    // Stage
    input wire rcp_pkg::rcp_out_s stage_o
);
    timeunit 1ns;
    timeprecision 1ps;
    import rcp_pkg::*;

    // ****
    // Tick phase, restarted with the design
    // ****
    logic [19:0] ph_q;
    logic [19:0] ph_d;
    assign ph_d = (ph_q == 20'(TICK_CYCLES - 1)) ? 20'h0 : ph_q + 20'h1;
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            ph_q <= 20'h0;
        end else begin
            ph_q <= ph_d;
        end
    end

    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!rst_n);

    a_ready_after_setup: assert property (
        psel && !penable |=> pready)
        else $error("pready missing after setup");
    a_ready_in_access: assert property (
        pready |-> psel && penable && $past(psel && !penable))
        else $error("pready outside access");
    a_err_with_ready: assert property (
        pslverr |-> pready)
        else $error("pslverr without pready");
    a_unmapped_refused: assert property (
        psel && !penable && paddr > OFS_THR_LAST |=>
        pslverr && prdata == 32'h0)
        else $error("unmapped access not refused");
    a_pulse_one_cycle: assert property (
        stage_o.release_pulse |=> !stage_o.release_pulse)
        else $error("release pulse too long");
    a_start_fall_pulse: assert property (
        $fell(stage_o.start) |-> stage_o.release_pulse)
        else $error("start fell without release");
    a_start_or_blocked: assert property (
        !(stage_o.start && stage_o.blocked))
        else $error("start and blocked together");
    a_blocked_cond: assert property (
        stage_o.blocked |-> stage_o.cond == COND_BLOCKED)
        else $error("blocked without blocked cond");
    a_pulse_on_tick: assert property (
        $rose(stage_o.release_pulse) |-> ph_q inside {[0:4]})
        else $error("release away from tick");
endmodule : rcp_stage_assertions

bind rcp_stage rcp_stage_assertions #(.TICK_CYCLES(TICK_CYCLES)) u_chk (
    .ref_clk(ref_clk), .rst_n(rst_n), .psel(psel), .penable(penable),
    .paddr(paddr), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .stage_o(stage_o)
);

/* tb/rcp_front_end.sv */
module rcp_front_end #(
    parameter int PERIOD = 40
) (
    // Clock and reset
    input wire logic ref_clk,
    input wire logic rst_n,
    // Bench control
    input wire logic [rcp_pkg::MEAS_W-1:0] lvl,
    input wire logic [2:0] fld,
    input wire logic side2,
    // Measurements
    output rcp_pkg::rcp_meas_s meas_side1,
    output rcp_pkg::rcp_meas_s meas_side2
);
    timeunit 1ns;
    timeprecision 1ps;
    import rcp_pkg::*;

    int cnt;
    logic [6:0][MEAS_W-1:0] frame;

    // Other fields inverted so a wrong selection shows
    always_comb begin
        for (int i = 0; i < 7; i++) begin
            frame[i] = ~lvl;
        end
        frame[6 - fld] = lvl;
    end

    // Phase offset keeps refresh at a fixed distance from the stage tick
    always @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            cnt <= 13;
            meas_side1 <= '0;
            meas_side2 <= '0;
        end else begin
            cnt <= (cnt == PERIOD - 1) ? 0 : cnt + 1;
            if (cnt == 0) begin
                meas_side1 <= side2 ? rcp_meas_s'(~frame) : frame;
                meas_side2 <= side2 ? frame : rcp_meas_s'(~frame);
            end
        end
    end
endmodule : rcp_front_end

/* tb/rcp_stage_bench.sv */
module rcp_stage_bench;
    timeunit 1ns;
    timeprecision 1ps;
    import rcp_pkg::*;

    typedef struct packed {
        logic rd;
        logic err;
        logic st;
        logic [31:0] data;
    } rcp_note_s;

    localparam int TICK = 40;
    localparam int WAIT = 3 * TICK;
    localparam int LIMIT = 20000;

    logic ref_clk, rst_n, psel, penable, pwrite, pready, pslverr;
    logic block_in, side2;
    logic [ADDR_W-1:0] paddr;
    logic [31:0] pwdata, prdata, seed;
    logic [GRP_W-1:0] setting_group;
    logic [MEAS_W-1:0] lvl;
    logic [2:0] fld;
    logic [THR_W-1:0] thr;
    rcp_meas_s meas_side1, meas_side2;
    rcp_out_s stage_o;
    rcp_note_s notes[$];
    rcp_note_s cur;
    int failures = 0;
    int num_checks = 0;
    int cyc = 0;
    int rel_seen = 0;
    int rel_exp = 0;

    initial begin
        ref_clk = 1'b0;
        forever #4 ref_clk = ~ref_clk;
    end

    rcp_stage #(.TICK_CYCLES(TICK)) dut (
        .ref_clk(ref_clk), .rst_n(rst_n), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .meas_side1(meas_side1),
        .meas_side2(meas_side2), .block_in(block_in),
        .setting_group(setting_group), .stage_o(stage_o)
    );

    rcp_front_end #(.PERIOD(TICK)) fe (
        .ref_clk(ref_clk), .rst_n(rst_n), .lvl(lvl), .fld(fld),
        .side2(side2), .meas_side1(meas_side1), .meas_side2(meas_side2)
    );

    // ****
    // Tasks
    // ****
    function automatic logic [31:0] xs(input logic [31:0] s);
        logic [31:0] v;
        v = s ^ (s << 13);
        v = v ^ (v >> 17);
        return v ^ (v << 5);
    endfunction : xs

    task automatic apb(input logic w, input logic [ADDR_W-1:0] a,
            input logic [31:0] d, input logic e);
        notes.push_back('{!w, e, !w && a == OFS_STATUS, w ? 32'h0 : d});
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge ref_clk);
        penable <= 1'b1;
        do begin
            @(posedge ref_clk);
        end while (pready !== 1'b1);
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge ref_clk);
    endtask : apb

    task automatic wr(input logic [ADDR_W-1:0] a, input logic [31:0] d,
            input logic e);
        apb(1'b1, a, d, e);
    endtask : wr

    task automatic rd(input logic [ADDR_W-1:0] a, input logic [31:0] x);
        apb(1'b0, a, x, 1'b0);
    endtask : rd

    // Waits out one refresh plus one stage evaluation
    task automatic setm(input int v);
        lvl <= MEAS_W'(v);
        repeat (WAIT) @(posedge ref_clk);
    endtask : setm

    task automatic chk_apb(input rcp_note_s n);
        num_checks++;
        if (pslverr !== n.err || (n.rd && prdata !== n.data)) begin
            failures++;
            $display("Error %0t: apb got %h err %b", $time, prdata, pslverr);
        end
    endtask : chk_apb

    // Stage outputs must agree with the condition code in status
    task automatic chk_out(input logic [5:0] s);
        num_checks++;
        if ({stage_o.start, stage_o.trip, stage_o.blocked, stage_o.test,
                stage_o.cond} !== {s[5:4] == 2'h1, s[5:4] == 2'h2,
                s[5:4] == 2'h3, s[3], s[5:4]}) begin
            failures++;
            $display("Error %0t: stage outputs %b", $time, stage_o);
        end
    endtask : chk_out

    task automatic chk_cnt();
        num_checks++;
        if (rel_seen != rel_exp) begin
            failures++;
            $display("Error %0t: release count %0d", $time, rel_seen);
        end
    endtask : chk_cnt

    task automatic stop_test();
        if (failures == 0 && num_checks > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask : stop_test

    always @(posedge ref_clk) begin
        cyc++;
        if (stage_o.release_pulse === 1'b1) begin
            rel_seen++;
        end
        if (psel && penable && pready === 1'b1 && notes.size() > 0) begin
            cur = notes.pop_front();
            chk_apb(cur);
            if (cur.st) begin
                chk_out(cur.data[5:0]);
            end
        end
        if (cyc == LIMIT) begin
            failures++;
            stop_test();
        end
    end

    // ****
    // Main sequence
    // ****
    initial begin
        rst_n = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = '0;
        pwdata = '0;
        block_in = 1'b0;
        side2 = 1'b0;
        setting_group = '0;
        lvl = '0;
        fld = '0;
        seed = xs(32'h1);
        thr = THR_W'(100 * (1 + seed % 3999));
        repeat (8) @(posedge ref_clk);
        rst_n <= 1'b1;
        @(posedge ref_clk);
        rd(OFS_CTRL, 32'h0);
        rd(OFS_GLOBAL, 32'h0);
        rd(OFS_THR_BASE, 32'(THR_RST));
        apb(1'b0, 12'h040, 32'h0, 1'b1);
        wr(OFS_THR_BASE, 32'(thr), 1'b0);
        setm(thr);
        rd(OFS_STATUS, 32'h0);
        setm(thr + 1);
        rd(OFS_STATUS, 32'h13);
        setm(thr / 100 * 97);
        rd(OFS_STATUS, 32'h13);
        setm(thr / 100 * 97 - 1);
        rd(OFS_STATUS, 32'h0);
        rel_exp++;
        for (int k = 0; k < 18; k++) begin
            wr(OFS_CTRL, 32'(k / 6 + 4 * (k / 2 % 3) + 16 * (k % 2)), 1'b0);
            fld <= 3'(k / 6 == 2 ? 6 : 3 * (k / 6) + k / 2 % 3);
            side2 <= k[0];
            setm(thr + 1);
            rd(OFS_STATUS, 32'h13);
            setm(0);
            rd(OFS_STATUS, 32'h0);
            rel_exp++;
        end
        wr(OFS_CTRL, 32'h0, 1'b0);
        fld <= 3'h0;
        side2 <= 1'b0;
        setm(thr + 1);
        block_in <= 1'b1;
        setm(thr + 1);
        rd(OFS_STATUS, 32'h35);
        rel_exp++;
        setm(0);
        rd(OFS_STATUS, 32'h0);
        setm(thr + 1);
        rd(OFS_STATUS, 32'h35);
        block_in <= 1'b0;
        setm(0);
        setm(2 * thr);
        rd(OFS_MEAS, 32'(2 * thr));
        rd(OFS_RATIO, 32'h200);
        setm(0);
        rel_exp++;
        wr(OFS_CTRL, 32'h100, 1'b0);
        rd(OFS_CTRL, 32'h0);
        wr(OFS_GLOBAL, 32'h1, 1'b0);
        for (int k = 2; k < 4; k++) begin
            wr(OFS_CTRL, 32'(k << 6), 1'b0);
            setm(0);
            rd(OFS_STATUS, 32'h8);
        end
        wr(OFS_CTRL, 32'h100, 1'b0);
        setm(thr + 1);
        rd(OFS_STATUS, 32'h0);
        wr(OFS_CTRL, 32'h140, 1'b1);
        wr(OFS_CTRL, 32'h40, 1'b0);
        setm(thr + 1);
        rd(OFS_STATUS, 32'h35);
        setm(0);
        wr(OFS_CTRL, 32'h0, 1'b0);
        wr(OFS_THR_BASE + 12'h4, 32'(thr + 7), 1'b0);
        wr(OFS_REMOTE, 32'(thr), 1'b1);
        setting_group <= 3'h1;
        rd(OFS_REMOTE, 32'(thr + 7));
        rd(OFS_CTRL, 32'h0);
        wr(OFS_CTRL, 32'h20, 1'b0);
        wr(OFS_REMOTE, 32'(thr + 9), 1'b0);
        rd(OFS_THR_BASE + 12'h4, 32'(thr + 9));
        wr(OFS_THR_BASE, 32'h0, 1'b1);
        wr(OFS_THR_BASE, 32'h61a81, 1'b1);
        wr(OFS_THR_BASE, 32'(THR_MAX), 1'b0);
        setm(thr + 10);
        rd(OFS_STATUS, 32'h13);
        setm(0);
        rel_exp++;
        // Forced start comes last: leaving it needs a reset
        for (int k = 0; k < 4; k++) begin
            int c;
            c = (k + 2) % 4;
            wr(OFS_GLOBAL, 32'(3 + 4 * c), 1'b0);
            rd(OFS_STATUS, 32'(16 * c));
        end
        rst_n <= 1'b0;
        repeat (2) @(posedge ref_clk);
        rst_n <= 1'b1;
        @(posedge ref_clk);
        rd(OFS_GLOBAL, 32'h0);
        chk_cnt();
        stop_test();
    end
endmodule : rcp_stage_bench
